// ---- pcnr_pkg.sv ----
// pcnr_pkg: constants shared by the pin change notify and input remap block
`default_nettype none

package pcnr_pkg;

   // =====================================================================
   // widths
   // =====================================================================
   localparam int PCNR_PORT_W = 16;            // pins of one port
   localparam int PCNR_ADDR_W = 4;             // register index width
   localparam int PCNR_DATA_W = 16;            // register data width
   localparam int PCNR_SEL_W  = 7;             // one remap selector field
   localparam int PCNR_RP_W   = 122;           // remappable inputs 0..121

   // =====================================================================
   // register offsets (register index on the plain port)
   // =====================================================================
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_CHG_EN    = 4'h0;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_PULLUP    = 4'h1;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_PULLDOWN  = 4'h2;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_CAP_SEL   = 4'h3;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_CHG_STAT  = 4'h4;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_IRQ_MASK  = 4'h5;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_PIN_STATE = 4'h6;
   localparam logic [PCNR_ADDR_W-1:0] PCNR_OFF_WAKE_STAT = 4'h7;

   // =====================================================================
   // field layout of the capture input select register
   // =====================================================================
   localparam int PCNR_CAP3_LSB = 0;
   localparam int PCNR_CAP3_MSB = 6;
   localparam int PCNR_CAP4_LSB = 8;
   localparam int PCNR_CAP4_MSB = 14;
   localparam logic [PCNR_DATA_W-1:0] PCNR_CAP_SEL_MASK = 16'h7f7f;

   // =====================================================================
   // selector codes
   // =====================================================================
   localparam logic [PCNR_SEL_W-1:0] PCNR_SEL_GND   = 7'h00;
   localparam logic [PCNR_SEL_W-1:0] PCNR_SEL_COMPARATOR_ONE_OUTPUT  = 7'h01;
   localparam logic [PCNR_SEL_W-1:0] PCNR_SEL_RP121 = 7'h79;

   // =====================================================================
   // reset values
   // =====================================================================
   localparam logic [PCNR_DATA_W-1:0] PCNR_RST_REG  = 16'h0000;
   localparam logic [PCNR_PORT_W-1:0] PCNR_RST_PINS = 16'h0000;
   localparam logic [PCNR_DATA_W-1:0] PCNR_RD_ZERO  = 16'h0000;

   // =====================================================================
   // sleep tracking states
   // =====================================================================
   typedef enum logic [1:0] {
      PCNR_AWAKE  = 2'b00,
      PCNR_ASLEEP = 2'b01,
      PCNR_WAKING = 2'b10
   } pcnr_sleep_t;

endpackage

`default_nettype wire

// ---- pcnr_input_mux.sv ----
// pcnr_input_mux: decodes one 7-bit selector into a capture input source
`timescale 1ns/1ps
`default_nettype none

module pcnr_input_mux (
   input  wire logic [pcnr_pkg::PCNR_SEL_W-1:0] sel_code,
   input  wire logic [pcnr_pkg::PCNR_RP_W-1:0]  remappable_pin_n,
   input  wire logic                            comparator_one_output,
   output logic                                 source_out
);
   import pcnr_pkg::*;

   // =====================================================================
   // selector decode
   // =====================================================================
   // codes above the highest pin tie low, so a stray value never floats
   always_comb begin
      if (sel_code == PCNR_SEL_GND) begin
         source_out = 1'b0;                             // RQ10
      end else if (sel_code == PCNR_SEL_COMPARATOR_ONE_OUTPUT) begin
         source_out = comparator_one_output;            // RQ10
      end else if (sel_code <= PCNR_SEL_RP121) begin
         source_out = remappable_pin_n[sel_code];       // RQ10
      end else begin
         source_out = 1'b0;
      end
   end

endmodule // pcnr_input_mux

`default_nettype wire

// ---- pcnr_top.sv ----
// pcnr_top: pin change notify, weak pull controls and capture input remap
//
// Contract
// RQ1 - enabled pin change raises interrupt request
// RQ2 - change detection still works while sleeping
// RQ3 - each port pin has its own selection
// RQ4 - enable bit set allows, clear blocks, pin
// RQ5 - set bits switch weak pull-up or pull-down
// RQ6 - pull-up and pull-down in separate registers
// RQ7 - software disables pulls on output pins
// RQ8 - software waits one cycle before port readback
// RQ9 - remap fields: 14-8 channel four, 6-0 three
// RQ10 - code 121 pin, 1 comparator, 0 ground
// RQ11 - bits 15 and 7 ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none

module pcnr_top (
   input  wire logic                             clk_sys,
   input  wire logic                             resetn,
   input  wire logic [pcnr_pkg::PCNR_ADDR_W-1:0] reg_addr,
   input  wire logic [pcnr_pkg::PCNR_DATA_W-1:0] reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic      [pcnr_pkg::PCNR_DATA_W-1:0] reg_rdata,
   input  wire logic [pcnr_pkg::PCNR_PORT_W-1:0] pin_in,
   input  wire logic                             sleep_mode,
   input  wire logic                             comparator_one_output,
   input  wire logic [pcnr_pkg::PCNR_RP_W-1:0]   remappable_pin_n,
   output logic                                  change_irq,
   output logic                                  wake_req,
   output logic      [pcnr_pkg::PCNR_PORT_W-1:0] pullup_en,
   output logic      [pcnr_pkg::PCNR_PORT_W-1:0] pulldown_en,
   output logic                                  capture_channel_three,
   output logic                                  capture_channel_four
);
   import pcnr_pkg::*;

   // =====================================================================
   // helpers
   // =====================================================================
   // one write decode shared by every register
   function automatic logic wr_hit(
      input logic                   wr,
      input logic [PCNR_ADDR_W-1:0] addr,
      input logic [PCNR_ADDR_W-1:0] off
   );
      wr_hit = wr && (addr == off);
   endfunction

   // =====================================================================
   // storage
   // =====================================================================
   logic [PCNR_PORT_W-1:0] change_irq_enable_reg;
   logic [PCNR_PORT_W-1:0] weak_pullup_enable_reg;
   logic [PCNR_PORT_W-1:0] weak_pulldown_enable_reg;
   logic [PCNR_DATA_W-1:0] capture_three_four_input_select;
   logic [PCNR_PORT_W-1:0] change_status;
   logic [PCNR_PORT_W-1:0] irq_mask;
   logic [PCNR_PORT_W-1:0] pin_last;
   logic                   pin_primed;
   logic                   wake_status;
   pcnr_sleep_t            sleep_state;
   pcnr_sleep_t            next_sleep_state;

   logic [PCNR_PORT_W-1:0] pin_state_change;
   logic                   any_change;
   logic [PCNR_DATA_W-1:0] next_rdata;
   logic                   next_capture_three;
   logic                   next_capture_four;
   logic                   next_change_irq;

   // =====================================================================
   // configuration registers
   // =====================================================================
   // per-pin notify enables, one bit for every pin of the port
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         change_irq_enable_reg <= PCNR_RST_REG;
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_CHG_EN)) begin
         change_irq_enable_reg <= reg_wdata;            // RQ3
      end
   end

   // pull-up enables live apart from pull-downs, so one never disturbs the other
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         weak_pullup_enable_reg <= PCNR_RST_REG;
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_PULLUP)) begin
         weak_pullup_enable_reg <= reg_wdata;           // RQ6
      end
   end

   // pull-down enables, their own register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         weak_pulldown_enable_reg <= PCNR_RST_REG;
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_PULLDOWN)) begin
         weak_pulldown_enable_reg <= reg_wdata;         // RQ6
      end
   end

   // capture remap selectors; the mask drops the two unimplemented bits
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         capture_three_four_input_select <= PCNR_RST_REG;
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_CAP_SEL)) begin
         capture_three_four_input_select <= reg_wdata & PCNR_CAP_SEL_MASK; // RQ11
      end
   end

   // interrupt mask, same layout as the status register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_mask <= PCNR_RST_REG;
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_IRQ_MASK)) begin
         irq_mask <= reg_wdata;
      end
   end

   // =====================================================================
   // weak pull drivers
   // =====================================================================
   // pulls follow the enable bits directly; software must keep them off on
   // pins it drives as outputs, the block does not police that
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pullup_en   <= PCNR_RST_PINS;
         pulldown_en <= PCNR_RST_PINS;
      end else begin
         pullup_en   <= weak_pullup_enable_reg;         // RQ5
         pulldown_en <= weak_pulldown_enable_reg;       // RQ5
      end
   end

   // =====================================================================
   // change detection
   // =====================================================================
   // last seen pin levels; the primed flag hides the reset snapshot so
   // that leaving reset with pins high does not look like a change
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_last   <= PCNR_RST_PINS;
         pin_primed <= 1'b0;
      end else begin
         pin_last   <= pin_in;
         pin_primed <= 1'b1;
      end
   end

   // a disabled pin contributes nothing, whatever it does
   always_comb begin
      if (pin_primed) begin
         pin_state_change = (pin_in ^ pin_last) & change_irq_enable_reg; // RQ4
      end else begin
         pin_state_change = PCNR_RST_PINS;
      end
      any_change = |pin_state_change;
   end

   // sticky per-pin status, write one to clear; a new change wins the clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         change_status <= PCNR_RST_PINS;
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_CHG_STAT)) begin
         change_status <= (change_status & ~reg_wdata) | pin_state_change; // RQ1
      end else begin
         change_status <= change_status | pin_state_change; // RQ1
      end
   end

   // =====================================================================
   // interrupt request
   // =====================================================================
   // level request while any unmasked status bit stands
   always_comb begin
      next_change_irq = |(change_status & irq_mask);    // RQ1
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         change_irq <= 1'b0;
      end else begin
         change_irq <= next_change_irq;                 // RQ1
      end
   end

   // =====================================================================
   // sleep tracking and wake request
   // =====================================================================
   // this logic runs on clk_sys, the one clock of the block: that clock keeps
   // running in sleep, so the same domain keeps watching the pins
   always_comb begin
      next_sleep_state = sleep_state;
      unique case (sleep_state)
         PCNR_AWAKE: begin
            if (sleep_mode) begin
               next_sleep_state = PCNR_ASLEEP;
            end
         end
         PCNR_ASLEEP: begin
            if (!sleep_mode) begin
               next_sleep_state = PCNR_AWAKE;
            end else if (any_change) begin
               next_sleep_state = PCNR_WAKING;          // RQ2
            end
         end
         PCNR_WAKING: begin
            if (!sleep_mode) begin
               next_sleep_state = PCNR_AWAKE;
            end
         end
         default: begin
            next_sleep_state = PCNR_AWAKE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sleep_state <= PCNR_AWAKE;
      end else begin
         sleep_state <= next_sleep_state;
      end
   end

   // wake request holds until the processor leaves sleep
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= (next_sleep_state == PCNR_WAKING); // RQ2
      end
   end

   // sticky record that a change woke the part; write one to clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wake_status <= 1'b0;
      end else if (sleep_state == PCNR_ASLEEP && any_change) begin
         wake_status <= 1'b1;                           // RQ2
      end else if (wr_hit(reg_wr, reg_addr, PCNR_OFF_WAKE_STAT) && reg_wdata[0]) begin
         wake_status <= 1'b0;
      end
   end

   // =====================================================================
   // capture input remap
   // =====================================================================
   // channel three from bits 6-0, channel four from bits 14-8
   pcnr_input_mux u_mux_three (
      .sel_code              (capture_three_four_input_select[PCNR_CAP3_MSB:PCNR_CAP3_LSB]), // RQ9
      .remappable_pin_n      (remappable_pin_n),
      .comparator_one_output (comparator_one_output),
      .source_out            (next_capture_three)
   );

   pcnr_input_mux u_mux_four (
      .sel_code              (capture_three_four_input_select[PCNR_CAP4_MSB:PCNR_CAP4_LSB]), // RQ9
      .remappable_pin_n      (remappable_pin_n),
      .comparator_one_output (comparator_one_output),
      .source_out            (next_capture_four)
   );

   // one register stage keeps the outputs glitch free at a cost of a cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         capture_channel_three <= 1'b0;
         capture_channel_four  <= 1'b0;
      end else begin
         capture_channel_three <= next_capture_three;   // RQ10
         capture_channel_four  <= next_capture_four;    // RQ10
      end
   end

   // =====================================================================
   // register read port
   // =====================================================================
   // unmapped offsets and idle cycles read as zero
   always_comb begin
      next_rdata = PCNR_RD_ZERO;
      if (reg_rd) begin
         unique case (reg_addr)
            PCNR_OFF_CHG_EN:    next_rdata = change_irq_enable_reg;
            PCNR_OFF_PULLUP:    next_rdata = weak_pullup_enable_reg;
            PCNR_OFF_PULLDOWN:  next_rdata = weak_pulldown_enable_reg;
            PCNR_OFF_CAP_SEL:   next_rdata = capture_three_four_input_select; // RQ11
            PCNR_OFF_CHG_STAT:  next_rdata = change_status;
            PCNR_OFF_IRQ_MASK:  next_rdata = irq_mask;
            PCNR_OFF_PIN_STATE: next_rdata = pin_last;
            PCNR_OFF_WAKE_STAT: next_rdata = {{(PCNR_DATA_W-1){1'b0}}, wake_status};
            default:            next_rdata = PCNR_RD_ZERO;
         endcase
      end
   end

   // read data stand for the one cycle after the strobe only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= PCNR_RD_ZERO;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule // pcnr_top

`default_nettype wire

// ---- pcnr_props.sv ----
// pcnr_props: port-level assertions for the pin change notify block
`timescale 1ns/1ps
`default_nettype none

module pcnr_props (
   input wire logic                             clk_sys,
   input wire logic                             resetn,
   input wire logic [pcnr_pkg::PCNR_ADDR_W-1:0] reg_addr,
   input wire logic [pcnr_pkg::PCNR_DATA_W-1:0] reg_wdata,
   input wire logic                             reg_wr,
   input wire logic                             reg_rd,
   input wire logic [pcnr_pkg::PCNR_DATA_W-1:0] reg_rdata,
   input wire logic [pcnr_pkg::PCNR_PORT_W-1:0] pin_in,
   input wire logic                             sleep_mode,
   input wire logic                             comparator_one_output,
   input wire logic [pcnr_pkg::PCNR_RP_W-1:0]   remappable_pin_n,
   input wire logic                             change_irq,
   input wire logic                             wake_req,
   input wire logic [pcnr_pkg::PCNR_PORT_W-1:0] pullup_en,
   input wire logic [pcnr_pkg::PCNR_PORT_W-1:0] pulldown_en,
   input wire logic                             capture_channel_three,
   input wire logic                             capture_channel_four
);
   import pcnr_pkg::*;

   // ==================
   // shadow registers
   // ==================
   logic [PCNR_DATA_W-1:0] en_sh, mask_sh, pu_sh, pd_sh, cap_sh, ever_en;
   logic                   src3, src4;

   // copy of what software wrote, so outputs are judged without peeking inside
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {en_sh, mask_sh, pu_sh, pd_sh, cap_sh} <= '0;
      end else if (reg_wr) begin
         if (reg_addr == PCNR_OFF_CHG_EN) en_sh <= reg_wdata;
         if (reg_addr == PCNR_OFF_IRQ_MASK) mask_sh <= reg_wdata;
         if (reg_addr == PCNR_OFF_PULLUP) pu_sh <= reg_wdata;
         if (reg_addr == PCNR_OFF_PULLDOWN) pd_sh <= reg_wdata;
         if (reg_addr == PCNR_OFF_CAP_SEL) cap_sh <= reg_wdata & PCNR_CAP_SEL_MASK;
      end
   end

   // pins ever enabled: a sticky status bit may outlive its enable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) ever_en <= '0;
      else ever_en <= ever_en | en_sh;
   end

   // reference selector decode; codes above the top pin tie low
   function automatic logic pick(input logic [6:0] c, input logic cmp, input logic [121:0] rp);
      if (c == PCNR_SEL_GND) return 1'b0;
      if (c == PCNR_SEL_COMPARATOR_ONE_OUTPUT) return cmp;
      if (c > PCNR_SEL_RP121) return 1'b0;
      return rp[c];
   endfunction

   // expected capture sources from each field
   assign src3 = pick(cap_sh[6:0], comparator_one_output, remappable_pin_n);
   assign src4 = pick(cap_sh[14:8], comparator_one_output, remappable_pin_n);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_pullup_copy: assert property (pullup_en == $past(pu_sh))
      else $error("pull-up enables differ from register");
   a_pulldown_copy: assert property (pulldown_en == $past(pd_sh))
      else $error("pull-down enables differ from register");
   a_cap_three: assert property (capture_channel_three == $past(src3))
      else $error("channel three source wrong");
   a_cap_four: assert property (capture_channel_four == $past(src4))
      else $error("channel four source wrong");
   a_change_irq: assert property (|((pin_in ^ $past(pin_in)) & en_sh & mask_sh)
      |-> ##[1:4] change_irq) else $error("enabled change gave no interrupt");
   a_irq_masked: assert property (change_irq |-> $past(|mask_sh))
      else $error("interrupt with all sources masked");
   a_wake_sleep: assert property (sleep_mode [*3] ##0
      (|((pin_in ^ $past(pin_in)) & en_sh)) |-> ##[0:3] wake_req)
      else $error("change in sleep gave no wake");
   a_wake_drop: assert property (!sleep_mode [*2] |-> !wake_req)
      else $error("wake held while awake");
   a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == PCNR_RD_ZERO)
      else $error("read data outside read cycle");
   a_read_cap: assert property ($past(reg_rd) && $past(reg_addr) == PCNR_OFF_CAP_SEL
      |-> reg_rdata == $past(cap_sh)) else $error("capture select readback wrong");
   a_status_subset: assert property ($past(reg_rd) && $past(reg_addr) == PCNR_OFF_CHG_STAT
      |-> (reg_rdata & ~ever_en) == '0) else $error("status bit of a disabled pin");
   a_read_unmapped: assert property ($past(reg_rd) && $past(reg_addr[3])
      |-> reg_rdata == PCNR_RD_ZERO) else $error("unmapped read not zero");

endmodule // pcnr_props

bind pcnr_top pcnr_props u_pcnr_props (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .pin_in, .sleep_mode, .comparator_one_output, .remappable_pin_n,
   .change_irq, .wake_req, .pullup_en, .pulldown_en, .capture_channel_three,
   .capture_channel_four);

`default_nettype wire

// ---- pcnr_cpu_model.sv ----
// pcnr_cpu_model: processor side that dozes on request and wakes on the block's call
`timescale 1ns/1ps
`default_nettype none

module pcnr_cpu_model (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic sleep_req,
   input  wire logic wake_req,
   output logic      sleep_mode
);
   // wake wins over a pending doze so a change is never lost
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) sleep_mode <= 1'b0;
      else if (wake_req) sleep_mode <= 1'b0;
      else if (sleep_req) sleep_mode <= 1'b1;
   end
endmodule // pcnr_cpu_model

`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for the pin change notify block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import pcnr_pkg::*;
   logic         clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic         sleep_req = 1'b0, sleep_mode, comparator_one_output = 1'b0;
   logic         change_irq, wake_req, capture_channel_three, capture_channel_four;
   logic [3:0]   reg_addr = '0;
   logic [15:0]  reg_wdata = '0, reg_rdata, pin_in = '0, pullup_en, pulldown_en;
   logic [121:0] remappable_pin_n = '0;
   int           fail_count = 0, check_count = 0, cycles = 0;

   pcnr_top u_pcnr_top (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pin_in, .sleep_mode, .comparator_one_output, .remappable_pin_n,
      .change_irq, .wake_req, .pullup_en, .pulldown_en, .capture_channel_three,
      .capture_channel_four);
   pcnr_cpu_model u_pcnr_cpu_model (.clk_sys, .resetn, .sleep_req, .wake_req, .sleep_mode);

   // clock; a hang is cut short well beyond the few hundred cycles the run needs
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle strobes; read data stands only in the cycle after the strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
      // a read never lands on the edge right after a write: one idle cycle first
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(what, exp, reg_rdata);
   endtask

   // bounded wait on the interrupt line
   task automatic irq_is(input logic exp);
      for (int n = 0; n < 8 && change_irq !== exp; n++) @(negedge clk_sys);
      chk("change_irq", {15'h0, exp}, {15'h0, change_irq});
   endtask

   task automatic t_regs();
      for (int i = 0; i < 16; i++) rd(i[3:0], 16'h0000, "reset value");
      wr(PCNR_OFF_CAP_SEL, 16'hffff);
      rd(PCNR_OFF_CAP_SEL, 16'h7f7f, "cap select");
      wr(4'h9, 16'hffff);
      rd(4'h9, 16'h0000, "unmapped");
   endtask

   task automatic t_pulls();
      wr(PCNR_OFF_PULLUP, 16'ha5a5);
      wr(PCNR_OFF_PULLDOWN, 16'h0f0f);
      // register takes the write at one edge, the pin enable follows one edge later
      repeat (2) @(negedge clk_sys);
      chk("pullup_en", 16'ha5a5, pullup_en);
      chk("pulldown_en", 16'h0f0f, pulldown_en);
      wr(PCNR_OFF_PULLUP, 16'h0000);
      repeat (2) @(negedge clk_sys);
      chk("pullup_en", 16'h0000, pullup_en);
      chk("pulldown_en", 16'h0f0f, pulldown_en);
      rd(PCNR_OFF_PULLDOWN, 16'h0f0f, "pulldown reg");
      // software leaves every pull off before the pins are exercised
      wr(PCNR_OFF_PULLDOWN, 16'h0000);
      repeat (2) @(negedge clk_sys);
      chk("pulldown_en", 16'h0000, pulldown_en);
   endtask

   task automatic t_remap();
      logic [6:0] tab [4][2] = '{'{7'h00, 7'h01}, '{7'h01, 7'h79}, '{7'h79, 7'h05},
                                 '{7'h05, 7'h00}};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         comparator_one_output <= 1'b1;
         remappable_pin_n <= {1'b1, 115'h0, 1'b1, 5'h0};
         wr(PCNR_OFF_CAP_SEL, {1'b0, tab[i][0], 1'b0, tab[i][1]});
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk("capture", {14'h0, tab[i][0] != 0, tab[i][1] != 0},
             {14'h0, capture_channel_four, capture_channel_three});
         @(posedge clk_sys);
         comparator_one_output <= 1'b0;
         remappable_pin_n <= '0;
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk("capture", 16'h0000, {14'h0, capture_channel_four, capture_channel_three});
      end
   endtask

   task automatic t_change();
      wr(PCNR_OFF_IRQ_MASK, 16'hffff);
      // every pin moves but only pin i is enabled
      for (int i = 0; i < 16; i++) begin
         wr(PCNR_OFF_CHG_EN, 16'h0001 << i);
         @(posedge clk_sys);
         pin_in <= ~pin_in;
         irq_is(1'b1);
         rd(PCNR_OFF_CHG_STAT, 16'h0001 << i, "change status");
         wr(PCNR_OFF_CHG_STAT, 16'h0001 << i);
         irq_is(1'b0);
      end
      wr(PCNR_OFF_IRQ_MASK, 16'h0000);
      @(posedge clk_sys);
      pin_in <= ~pin_in;
      repeat (4) @(negedge clk_sys);
      chk("change_irq", 16'h0000, {15'h0, change_irq});
      wr(PCNR_OFF_IRQ_MASK, 16'h8000);
      irq_is(1'b1);
      wr(PCNR_OFF_CHG_STAT, 16'hffff);
      irq_is(1'b0);
   endtask

   task automatic t_sleep();
      wr(PCNR_OFF_CHG_EN, 16'h0001);
      @(posedge clk_sys);
      sleep_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pin_in[0] <= ~pin_in[0];
      for (int n = 0; n < 8 && wake_req !== 1'b1; n++) @(negedge clk_sys);
      chk("wake_req", 16'h0001, {15'h0, wake_req});
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      rd(PCNR_OFF_WAKE_STAT, 16'h0001, "wake status");
      wr(PCNR_OFF_WAKE_STAT, 16'h0001);
      rd(PCNR_OFF_WAKE_STAT, 16'h0000, "wake status");
      chk("wake_req", 16'h0000, {15'h0, wake_req});
   endtask

   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_pulls();
      t_remap();
      t_change();
      t_sleep();
      results();
   end
endmodule // tb_top

`default_nettype wire
